//--- fhb_device.sv
`timescale 1ns/10ps
// Purpose: flash device end: pin decode, command latches, array, burst engine
// Assumes: pins come from another party; each passes two flip-flops first
// Notes:   burst data is buffered in an 8-word FIFO ahead of the bus drivers
module fhb_device (
	input  wire logic SYS_CLK_I,
	input  wire logic RSTN_I,
	fhb_if.device     BUS
);
	// ============================================================
	// pin synchronisers
	// ============================================================
	logic [5:0]  pin_s1_q;
	logic [5:0]  pin_s2_q;
	logic [15:0] dq_s1_q;
	logic [15:0] dq_s2_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			// idle levels of the pins; the clock pin idles low, so no false edge follows reset
			pin_s1_q <= 6'h3d;
			pin_s2_q <= 6'h3d;
			dq_s1_q  <= 16'h0000;
			dq_s2_q  <= 16'h0000;
		end else begin
			pin_s1_q <= {BUS.ce_n, BUS.oe_n, BUS.we_n, BUS.rst_n,
				BUS.burst_clk, BUS.address_valid_strobe_n};
			pin_s2_q <= pin_s1_q;
			dq_s1_q  <= BUS.muxed_addr_data_lines;
			dq_s2_q  <= dq_s1_q;
		end
	end
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic prst_n;
	logic bclk;
	logic avd_n;
	assign {ce_n, oe_n, we_n, prst_n, bclk, avd_n} = pin_s2_q;
	logic avd_q;
	logic bclk_q;
	logic we_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			avd_q  <= 1'b1;
			bclk_q <= 1'b0;
			we_q   <= 1'b1;
		end else begin
			avd_q  <= avd_n;
			bclk_q <= bclk;
			we_q   <= we_n;
		end
	end
	logic avd_rise;
	logic bclk_rise;
	logic we_rise;
	assign avd_rise  = avd_n && !avd_q;
	assign bclk_rise = bclk && !bclk_q;
	assign we_rise   = we_n && !we_q;
	logic active;
	assign active = prst_n && !ce_n;

	// ============================================================
	// array, address latch, command latches
	// ============================================================
	logic [15:0] array_mem [fhb_pkg::MEM_WORDS];
	logic [15:0] addr_q;
	logic [15:0] cmd_q;
	logic [15:0] cmd_addr_q;
	logic [15:0] cmd_data_q;
	logic        burst_en_q;
	fhb_pkg::fhb_op_e mode_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			addr_q <= 16'h0000;
		end else if (active && we_n && avd_rise) begin
			addr_q <= dq_s2_q;
		end else if (active && !avd_n) begin
			addr_q <= dq_s2_q;
		end
	end
	// command latches: held apart from the array so reads never see them
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			cmd_q      <= 16'h0000;
			cmd_addr_q <= 16'h0000;
			cmd_data_q <= 16'h0000;
		end else if (active && oe_n && we_rise) begin
			cmd_addr_q <= addr_q;
			cmd_data_q <= dq_s2_q;
			cmd_q      <= (mode_q == fhb_pkg::FHB_OP_WRITE) ? cmd_q : dq_s2_q;
		end
	end
	// command state machine: program takes the next write as its data
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I || !prst_n) begin
			mode_q     <= fhb_pkg::FHB_OP_READ;
			burst_en_q <= 1'b0;
		end else if (active && oe_n && we_rise) begin
			unique case (mode_q)
				fhb_pkg::FHB_OP_WRITE: begin
					mode_q <= fhb_pkg::FHB_OP_READ;
				end
				default: begin
					if (dq_s2_q == fhb_pkg::CMD_RESET) begin
						mode_q <= fhb_pkg::FHB_OP_READ;
					end else if (dq_s2_q == fhb_pkg::CMD_PROG) begin
						mode_q <= fhb_pkg::FHB_OP_WRITE;
					end else if (dq_s2_q[15:8] == fhb_pkg::CMD_CFG_WR[7:0]) begin
						burst_en_q <= dq_s2_q[0];
						mode_q     <= dq_s2_q[0] ? fhb_pkg::FHB_OP_BURST : fhb_pkg::FHB_OP_READ;
					end
				end
			endcase
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (active && oe_n && we_rise && mode_q == fhb_pkg::FHB_OP_WRITE) begin
			array_mem[addr_q[fhb_pkg::MEM_AW-1:0]] <= dq_s2_q;
		end
	end

	// ============================================================
	// burst engine feeding the FIFO
	// ============================================================
	logic [15:0] baddr_q;
	logic        bact_q;
	logic        f_ready;
	logic        f_valid;
	logic [15:0] f_data;
	logic        f_pop;
	logic        f_flush;
	assign f_flush = !RSTN_I || !active || (we_n && avd_rise);
	always_ff @(posedge SYS_CLK_I) begin
		if (f_flush) begin
			bact_q  <= RSTN_I && active && burst_en_q;
			baddr_q <= dq_s2_q;
		end else if (bact_q && f_ready) begin
			// prefetch runs ahead of the clock, so the first edge already pops word zero
			baddr_q <= baddr_q + 16'h0001;
		end
	end
	assign f_pop = bact_q && !oe_n && avd_n && bclk_rise;
	fhb_fifo #(.WIDTH(fhb_pkg::DATA_W), .DEPTH(fhb_pkg::FIFO_DEPTH)) u_fifo (
		.clk_i      (SYS_CLK_I),
		.rst_n_i    (!f_flush),
		.in_valid_i (bact_q),
		.in_ready_o (f_ready),
		.in_data_i  (array_mem[baddr_q[fhb_pkg::MEM_AW-1:0]]),
		.out_valid_o(f_valid),
		.out_ready_i(f_pop),
		.out_data_o (f_data)
	);

	// ============================================================
	// output drivers
	// ============================================================
	logic [3:0]  oe_cnt_q;
	logic [15:0] dout_q;
	logic        doe_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I || !active || oe_n || !we_n) begin
			oe_cnt_q <= 4'h0;
		end else if (oe_cnt_q != 4'(fhb_pkg::OE_ACCESS_CYC)) begin
			oe_cnt_q <= oe_cnt_q + 4'h1;
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I || !active || oe_n || !we_n) begin
			doe_q  <= 1'b0;
			dout_q <= 16'h0000;
		end else if (bact_q) begin
			doe_q <= f_valid;
			if (f_pop && f_valid) dout_q <= f_data;
		end else if (oe_cnt_q == 4'(fhb_pkg::OE_ACCESS_CYC)) begin
			doe_q  <= 1'b1;
			dout_q <= array_mem[addr_q[fhb_pkg::MEM_AW-1:0]];
		end
	end
	assign BUS.dev_dq_o  = dout_q;
	assign BUS.dev_dq_oe = doe_q;
endmodule // fhb_device

//--- fhb_fifo.sv
`timescale 1ns/10ps
// Purpose: small synchronous valid/ready FIFO
// Assumes: one clock, synchronous active-low reset
// Notes:   full and empty are exact; no bypass path
module fhb_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;
	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem[rd_q];
	assign push = in_valid_i && in_ready_o;
	assign pop  = out_valid_o && out_ready_i;
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // fhb_fifo

//--- fhb_host.sv
`timescale 1ns/10ps
// Purpose: host controller end: turns user requests into pin sequences
// Assumes: one request at a time; burst only after enabling it
// Notes:   burst clock is a divided copy of SYS_CLK_I driven out
module fhb_host (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        REQ_VALID_I,
	input  wire logic [1:0]  REQ_OP_I,
	input  wire logic [15:0] REQ_ADDR_I,
	input  wire logic [15:0] REQ_DATA_I,
	input  wire logic [3:0]  REQ_LEN_I,
	input  wire logic        PIN_RESET_I,
	output logic             REQ_READY_O,
	output logic             RSP_VALID_O,
	output logic      [15:0] RSP_DATA_O,
	fhb_if.host              BUS
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000, H_ADDR = 3'b001, H_WAIT = 3'b010,
		H_READ = 3'b011, H_WR   = 3'b100, H_BCLK = 3'b101, H_END = 3'b110
	} fhb_hst_e;
	fhb_hst_e    st_q;
	logic [15:0] data_q;
	logic [1:0]  op_q;
	logic [3:0]  cnt_q;
	logic [3:0]  len_q;
	logic [15:0] dq_s1_q;
	logic [15:0] dq_s2_q;
	logic        ce_q, oe_q, we_q, avd_q, clk_q, dqoe_q, rst_q, rdy_q, rv_q;
	logic [15:0] dqo_q, rd_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end else begin
			dq_s1_q <= BUS.muxed_addr_data_lines;
			dq_s2_q <= dq_s1_q;
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			rst_q <= 1'b0;
		end else begin
			rst_q <= !PIN_RESET_I;
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I || PIN_RESET_I) begin
			st_q   <= H_IDLE;
			ce_q   <= 1'b1;
			oe_q   <= 1'b1;
			we_q   <= 1'b1;
			avd_q  <= 1'b1;
			clk_q  <= 1'b0;
			dqoe_q <= 1'b0;
			dqo_q  <= 16'h0000;
			rdy_q  <= 1'b0;
			rv_q   <= 1'b0;
			rd_q   <= 16'h0000;
			cnt_q  <= 4'h0;
			len_q  <= 4'h0;
			op_q   <= 2'b00;
			data_q <= 16'h0000;
		end else begin
			rv_q <= 1'b0;
			unique case (st_q)
				H_IDLE: begin
					// ready must not wait for valid to drop, or a waiting request locks up
					rdy_q <= 1'b1;
					clk_q <= 1'b0;
					if (REQ_VALID_I && rdy_q) begin
						op_q <= REQ_OP_I;
						data_q <= REQ_DATA_I;
						len_q <= REQ_LEN_I;
						rdy_q <= 1'b0;
						ce_q <= 1'b0;
						avd_q <= 1'b0;
						we_q <= 1'b1;
						dqoe_q <= 1'b1;
						dqo_q <= REQ_ADDR_I;
						cnt_q <= 4'h4;
						st_q <= H_ADDR;
					end
				end
				H_ADDR: begin
					if (cnt_q != 4'h0) begin
						cnt_q <= cnt_q - 4'h1;
						if (op_q == 2'(fhb_pkg::FHB_OP_BURST) && cnt_q == 4'h2) clk_q <= 1'b1;
					end else begin
						avd_q <= 1'b1;
						clk_q <= 1'b0;
						cnt_q <= 4'h4;
						st_q <= (op_q == 2'(fhb_pkg::FHB_OP_WRITE)) ? H_WR : H_WAIT;
					end
				end
				H_WR: begin
					dqo_q <= data_q;
					we_q <= 1'b0;
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						we_q <= 1'b1;
						st_q <= H_END;
						cnt_q <= 4'h4;
					end
				end
				H_WAIT: begin
					dqoe_q <= 1'b0;
					oe_q <= 1'b0;
					cnt_q <= 4'(fhb_pkg::OE_ACCESS_CYC + 6);
					st_q <= (op_q == 2'(fhb_pkg::FHB_OP_BURST)) ? H_BCLK : H_READ;
				end
				H_READ: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						rd_q <= dq_s2_q;
						rv_q <= 1'b1;
						st_q <= H_END;
						cnt_q <= 4'h4;
					end
				end
				H_BCLK: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						cnt_q <= 4'(fhb_pkg::CLK_DIV * 4 - 1);
						clk_q <= !clk_q;
						if (clk_q) begin
							rd_q <= dq_s2_q;
							rv_q <= BUS.dev_dq_oe;
							len_q <= len_q - 4'h1;
							if (len_q == 4'h0) st_q <= H_END;
						end
					end
				end
				H_END: begin
					ce_q <= 1'b1;
					oe_q <= 1'b1;
					dqoe_q <= 1'b0;
					clk_q <= 1'b0;
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) st_q <= H_IDLE;
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end
	assign BUS.ce_n = ce_q;
	assign BUS.oe_n = oe_q;
	assign BUS.we_n = we_q;
	assign BUS.rst_n = rst_q;
	assign BUS.burst_clk = clk_q;
	assign BUS.address_valid_strobe_n = avd_q;
	assign BUS.host_dq_o = dqo_q;
	assign BUS.host_dq_oe = dqoe_q;
	assign REQ_READY_O = rdy_q;
	assign RSP_VALID_O = rv_q;
	assign RSP_DATA_O = rd_q;
endmodule // fhb_host

//--- fhb_if.sv
`timescale 1ns/10ps
// Purpose: pins between host controller and flash device
// Assumes: both ends on SYS_CLK_I
// Notes:   the muxed lines resolve from the two enables here
interface fhb_if;
	logic        ce_n;
	logic        oe_n;
	logic        we_n;
	logic        rst_n;
	logic        burst_clk;
	logic        address_valid_strobe_n;
	logic [15:0] host_dq_o;
	logic        host_dq_oe;
	logic [15:0] dev_dq_o;
	logic        dev_dq_oe;
	logic [15:0] muxed_addr_data_lines;
	assign muxed_addr_data_lines = host_dq_oe ? host_dq_o : (dev_dq_oe ? dev_dq_o : 16'hffff);
	modport host (output ce_n, oe_n, we_n, rst_n, burst_clk, address_valid_strobe_n,
		host_dq_o, host_dq_oe, input dev_dq_oe, muxed_addr_data_lines);
	modport device (input ce_n, oe_n, we_n, rst_n, burst_clk, address_valid_strobe_n,
		host_dq_o, host_dq_oe, muxed_addr_data_lines, output dev_dq_o, dev_dq_oe);
endinterface

//--- fhb_pkg.sv
// Purpose: shared constants for the flash host bus control decode (both ends)
// Assumes: 100 MHz SYS_CLK_I, 16-bit multiplexed address/data bus
// Notes:   pin levels are active low where the name ends in _n
package fhb_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int MEM_WORDS = 256;
	localparam int MEM_AW = 8;
	localparam int FIFO_DEPTH = 8;
	// output enable access time in ns, and in whole cycles (rounded up)
	localparam int OE_ACCESS_NS = 20;
	localparam int CLK_PERIOD_NS = 10;
	localparam int OE_ACCESS_CYC = (OE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// host divider: burst clock pin toggles once per CLK_DIV*4 system cycles
	localparam int CLK_DIV = 2;
	// command words
	localparam logic [15:0] CMD_RESET = 16'h00f0;
	localparam logic [15:0] CMD_CFG_WR = 16'h00d0;
	localparam logic [15:0] CMD_PROG = 16'h00a0;
	localparam logic [15:0] CFG_BURST_BIT = 16'h0001;
	typedef enum logic [1:0] {
		FHB_OP_READ  = 2'b00,
		FHB_OP_WRITE = 2'b01,
		FHB_OP_BURST = 2'b10
	} fhb_op_e;
endpackage

//--- fhb_properties.sv
// Purpose: pin-level checks on the bus between the two ends
// Assumes: every pin sampled on SYS_CLK_I
// Notes:   device pins pass three flops before a drive change shows
`timescale 1ns/10ps
module fhb_properties (
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic rst_n,
	input wire logic address_valid_strobe_n,
	input wire logic host_dq_oe,
	input wire logic dev_dq_oe
);
	// ==========================================================
	// sequences
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	sequence oe_opens;
		$fell(oe_n) && !ce_n && rst_n;
	endsequence
	sequence data_drives;
		dev_dq_oe || ce_n || !rst_n;
	endsequence
	// ==========================================================
	// properties
	a_bus_no_clash: assert property (!(host_dq_oe && dev_dq_oe))
		else $error("both ends drive the muxed lines");
	a_oe_after_strobe: assert property ($fell(oe_n) |-> address_valid_strobe_n)
		else $error("output enable fell while strobe low");
	a_strobe_with_ce: assert property (!address_valid_strobe_n |-> !ce_n)
		else $error("strobe low without chip select");
	a_write_oe_high: assert property (!we_n |-> oe_n && !ce_n)
		else $error("write without chip select or with output enable");
	a_write_host_drives: assert property (!we_n |-> host_dq_oe)
		else $error("write while host not driving");
	// three flops of latency, so five low samples leave margin
	a_reset_floats: assert property (!rst_n [*5] |-> !dev_dq_oe)
		else $error("device drives during hardware reset");
	a_standby_floats: assert property (ce_n [*5] |-> !dev_dq_oe)
		else $error("device drives while deselected");
	a_oe_idle_floats: assert property (oe_n [*5] |-> !dev_dq_oe)
		else $error("device drives with output enable high");
	a_oe_access_data: assert property (oe_opens |-> ##[1:12] data_drives)
		else $error("no read data after output enable");
endmodule // fhb_properties

//--- flash_host_bus_control_decode_tb.sv
// Purpose: self-checking bench for host and device ends joined by fhb_if
// Assumes: inputs driven at the falling edge, responses sampled there too
// Notes:   array is programmed before any read since its contents start unknown
`timescale 1ns/10ps
module flash_host_bus_control_decode_tb;
	logic        sys_clk;
	logic        rstn;
	logic        req_valid;
	logic [1:0]  req_op;
	logic [15:0] req_addr;
	logic [15:0] req_data;
	logic [3:0]  req_len;
	logic        pin_reset;
	logic        req_ready;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	logic [15:0] mem [256];
	logic [15:0] rsp_q [$];
	logic [15:0] wa [14];
	int          fails;
	int          checks_done;
	int          seed;
	// ==========================================================
	// design and checker
	fhb_if fhb_if_inst ();
	fhb_host fhb_host_inst (.SYS_CLK_I(sys_clk), .RSTN_I(rstn), .REQ_VALID_I(req_valid),
		.REQ_OP_I(req_op), .REQ_ADDR_I(req_addr), .REQ_DATA_I(req_data), .REQ_LEN_I(req_len),
		.PIN_RESET_I(pin_reset), .REQ_READY_O(req_ready), .RSP_VALID_O(rsp_valid),
		.RSP_DATA_O(rsp_data), .BUS(fhb_if_inst));
	fhb_device fhb_device_inst (.SYS_CLK_I(sys_clk), .RSTN_I(rstn), .BUS(fhb_if_inst));
	fhb_properties fhb_properties_inst (.SYS_CLK_I(sys_clk), .RSTN_I(rstn),
		.ce_n(fhb_if_inst.ce_n), .oe_n(fhb_if_inst.oe_n), .we_n(fhb_if_inst.we_n),
		.rst_n(fhb_if_inst.rst_n), .address_valid_strobe_n(fhb_if_inst.address_valid_strobe_n),
		.host_dq_oe(fhb_if_inst.host_dq_oe), .dev_dq_oe(fhb_if_inst.dev_dq_oe));
	always #5 sys_clk = ~sys_clk;
	// pulse lasts one cycle, so exactly one falling edge sees it
	always @(negedge sys_clk) begin
		if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
	end
	// ==========================================================
	// tasks
	task automatic complete_run();
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// word i of an access starting at a, from the bench's own copy of the array
	function automatic logic [15:0] exp_word(input logic [15:0] a, input int i);
		return mem[8'(a + i)];
	endfunction
	task automatic timeout();
		fails++;
		$display("mismatch at %0t: wait ran out", $time);
		complete_run();
	endtask
	// one idle edge first, so valid never drops and rises in one step
	task automatic req(input logic [1:0] op, input logic [15:0] a, input logic [15:0] d,
		input logic [3:0] len);
		int i;
		@(negedge sys_clk);
		req_op = op;
		req_addr = a;
		req_data = d;
		req_len = len;
		req_valid = 1'b1;
		for (i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge sys_clk);
		if (i == 400) timeout();
		@(negedge sys_clk);
		req_valid = 1'b0;
	endtask
	task automatic prog(input logic [15:0] a, input logic [15:0] d);
		req(fhb_pkg::FHB_OP_WRITE, 16'h0000, fhb_pkg::CMD_PROG, 4'h0);
		req(fhb_pkg::FHB_OP_WRITE, a, d, 4'h0);
		mem[a[7:0]] = d;
	endtask
	task automatic fetch(input logic [1:0] op, input logic [15:0] a, input int n);
		int i;
		rsp_q.delete();
		req(op, a, 16'h0000, 4'(n - 1));
		for (i = 0; i < 600 && rsp_q.size() < n; i++) @(negedge sys_clk);
		if (i == 600) timeout();
		for (i = 0; i < n; i++) chk(rsp_q[i], exp_word(a, i));
	endtask
	// ==========================================================
	// main sequence
	initial begin
		int k;
		seed = 32'h23606a04;
		sys_clk = 1'b0;
		rstn = 1'b0;
		req_valid = 1'b0;
		req_op = 2'h0;
		req_addr = 16'h0000;
		req_data = 16'h0000;
		req_len = 4'h0;
		pin_reset = 1'b0;
		repeat (10) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (2) @(negedge sys_clk);
		for (k = 0; k < 14; k++) begin
			wa[k] = (k < 8) ? 16'h0040 + 16'(k) : {8'h00, 8'($random(seed))};
			prog(wa[k], 16'($random(seed)));
		end
		// reverse order and a repeat: async reads take any address sequence
		for (k = 13; k >= 0; k--) fetch(fhb_pkg::FHB_OP_READ, wa[k], 1);
		fetch(fhb_pkg::FHB_OP_READ, wa[0], 1);
		req(fhb_pkg::FHB_OP_WRITE, 16'h0040, fhb_pkg::CMD_RESET, 4'h0);
		fetch(fhb_pkg::FHB_OP_READ, 16'h0040, 1);
		req(fhb_pkg::FHB_OP_WRITE, 16'h0000,
			{fhb_pkg::CMD_CFG_WR[7:0], 8'h00} | fhb_pkg::CFG_BURST_BIT, 4'h0);
		fetch(fhb_pkg::FHB_OP_BURST, 16'h0040, 8);
		fetch(fhb_pkg::FHB_OP_BURST, 16'h0043, 1);
		fetch(fhb_pkg::FHB_OP_BURST, 16'h0044, 4);
		// hardware reset at the end of a burst request's address phase, then the array must read back async
		req(fhb_pkg::FHB_OP_BURST, 16'h0040, 16'h0000, 4'h7);
		repeat (4) @(negedge sys_clk);
		pin_reset = 1'b1;
		repeat (8) @(negedge sys_clk);
		pin_reset = 1'b0;
		repeat (20) @(negedge sys_clk);
		fetch(fhb_pkg::FHB_OP_READ, 16'h0045, 1);
		// burst switched on and off again: reads must fall back to async
		req(fhb_pkg::FHB_OP_WRITE, 16'h0000,
			{fhb_pkg::CMD_CFG_WR[7:0], 8'h00} | fhb_pkg::CFG_BURST_BIT, 4'h0);
		req(fhb_pkg::FHB_OP_WRITE, 16'h0000, {fhb_pkg::CMD_CFG_WR[7:0], 8'h00}, 4'h0);
		fetch(fhb_pkg::FHB_OP_READ, 16'h0046, 1);
		complete_run();
	end
endmodule // flash_host_bus_control_decode_tb
